//--- rtl/pgia_top.v
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "pgia_defs.vh"

module pgia_top #(
    parameter [`PGIA_CNT_W-1:0] CLIP_HOLD_CYC =
        `PGIA_CLIP_HOLD_US * `PGIA_CLK_MHZ
) (
    // clock and reset
    input wire CLK_IN,
    input wire RESETN_IN,
    // apb slave
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    output wire [31:0] PRDATA_OUT,
    output wire PREADY_OUT,
    output wire PSLVERR_OUT,
    // analog monitors, asynchronous
    input wire OVERVOLT_IN,
    input wire [`PGIA_CLIP_W-1:0] CLIP_IN,
    // checksum fault from the register map checker
    input wire REGMAP_CRC_FAULT_IN,
    // input switch drives
    output wire CH1_POS_SWITCH_OUT,
    output wire CH1_NEG_SWITCH_OUT,
    output wire CH2_POS_SWITCH_OUT,
    output wire CH2_NEG_SWITCH_OUT,
    output wire TEST_ROUTE_SWITCH_POS_OUT,
    output wire TEST_ROUTE_SWITCH_NEG_OUT,
    output wire INPUT_SHORT_SWITCH_OUT,
    // resistor selects and total gain
    output wire [`PGIA_IRES_W-1:0] IN_RES_SEL_OUT,
    output wire [`PGIA_ORES_W-1:0] OUT_RES_SEL_OUT,
    output wire [`PGIA_TOT_W-1:0] GAIN_OUT,
    // interrupt
    output wire IRQ_OUT
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg [`PGIA_GAIN_W-1:0] gain_select_reg;
    reg [`PGIA_GAIN_W-1:0] gain_select_next;
    reg [`PGIA_SW_W-1:0] switch_ctrl_reg;
    reg [`PGIA_SW_W-1:0] switch_ctrl_next;
    reg [`PGIA_ST_W-1:0] fault_stat_reg;
    reg [`PGIA_ST_W-1:0] fault_stat_next;
    reg [`PGIA_DIS_W-1:0] fault_mask_reg;
    reg [`PGIA_DIS_W-1:0] fault_mask_next;
    reg [`PGIA_ST_W-1:0] irq_en_reg;
    reg [`PGIA_ST_W-1:0] irq_en_next;
    reg [`PGIA_CNT_W-1:0] clip_cnt_reg;
    reg [`PGIA_CNT_W-1:0] clip_cnt_next;
    reg pready_reg;
    reg pslverr_reg;
    reg [31:0] prdata_reg;
    reg [31:0] rd_mux;
    reg rd_hit;
    reg irq_reg;
    reg sw_c1p_reg;
    reg sw_c1n_reg;
    reg sw_c2p_reg;
    reg sw_c2n_reg;
    reg sw_tp_reg;
    reg sw_tn_reg;
    reg sw_sh_reg;
    wire [`PGIA_CLIP_W:0] mon_sync;
    wire ov_live;
    wire clip_any;
    wire apb_access;
    wire wr_fire;
    wire [`PGIA_ST_W-1:0] w1c_mask;
    wire [`PGIA_ST_W-1:0] stat_set;
    wire clip_hold_hit;
    wire restore_fire;
    wire gain_changes;
    wire ov_open;
    wire guard_on;
    wire ch1_req;
    wire ch2_block;

    // ------------------------------------------------------------
    // monitor synchronisers
    // ------------------------------------------------------------
    pgia_sync #(
        .W(`PGIA_CLIP_W + 1)
    ) u_sync (
        .clk(CLK_IN),
        .resetn(RESETN_IN),
        .d_in({OVERVOLT_IN, CLIP_IN}),
        .q_out(mon_sync)
    );

    // split synchronised monitors
    assign ov_live = mon_sync[`PGIA_CLIP_W];
    assign clip_any = |mon_sync[`PGIA_CLIP_W-1:0]; // RULE_12

    // ------------------------------------------------------------
    // apb handshake
    // ------------------------------------------------------------
    // one wait state, commit when pready is seen high
    assign apb_access = PSEL_IN & PENABLE_IN;
    assign wr_fire = apb_access & pready_reg & PWRITE_IN;

    // address decode for read data and error
    always @* begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (PADDR_IN)
            `PGIA_OFF_GAIN: begin
                rd_mux[`PGIA_GAIN_W-1:0] = gain_select_reg;
            end
            `PGIA_OFF_SW: begin
                rd_mux[`PGIA_SW_W-1:0] = switch_ctrl_reg;
            end
            `PGIA_OFF_STAT: begin
                rd_mux[`PGIA_ST_W-1:0] = fault_stat_reg;
            end
            `PGIA_OFF_DIS: begin
                rd_mux[`PGIA_DIS_W-1:0] = fault_mask_reg;
            end
            `PGIA_OFF_IRQEN: begin
                rd_mux[`PGIA_ST_W-1:0] = irq_en_reg;
            end
            `PGIA_OFF_LIVE: begin
                rd_mux[`PGIA_LIVE_W-1:0] =
                    {(clip_cnt_reg != {`PGIA_CNT_W{1'b0}}),
                     clip_any, ov_live};
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // ready, error and read data registers
    always @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= apb_access & ~pready_reg;
            if (apb_access & ~pready_reg) begin
                pslverr_reg <= ~rd_hit;
                if (PWRITE_IN) begin
                    prdata_reg <= 32'h00000000;
                end else begin
                    prdata_reg <= rd_mux;
                end
            end else begin
                pslverr_reg <= 1'b0;
                prdata_reg <= 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------
    // clipping persistence timer
    // ------------------------------------------------------------
    // counts clipping cycles, saturates one past the hold
    always @* begin
        clip_cnt_next = clip_cnt_reg;
        if (!clip_any) begin
            clip_cnt_next = {`PGIA_CNT_W{1'b0}}; // RULE_16
        end else if (clip_cnt_reg <= CLIP_HOLD_CYC) begin
            clip_cnt_next = clip_cnt_reg + 16'h0001; // RULE_16
        end
    end

    // fires once per clipping episode
    assign clip_hold_hit = clip_any & (clip_cnt_reg == CLIP_HOLD_CYC);
    // RULE_15 gates the restore
    assign restore_fire = clip_hold_hit &
        ~fault_mask_reg[`PGIA_DIS_GRST]; // RULE_13
    assign gain_changes = gain_select_reg != `PGIA_GAIN_RST;

    // ------------------------------------------------------------
    // fault status, set beats clear
    // ------------------------------------------------------------
    assign stat_set[`PGIA_ST_OV] = ov_live &
        ~fault_mask_reg[`PGIA_DIS_OV]; // RULE_07 RULE_09
    assign stat_set[`PGIA_ST_CLIP] = clip_any; // RULE_12
    assign stat_set[`PGIA_ST_GRST] = restore_fire; // RULE_13
    // restore may leave the checksum stale; only flagged
    assign stat_set[`PGIA_ST_CRC] = REGMAP_CRC_FAULT_IN |
        (restore_fire & gain_changes); // RULE_14

    // write-one-to-clear strobe
    assign w1c_mask = (wr_fire && PADDR_IN == `PGIA_OFF_STAT) ?
        PWDATA_IN[`PGIA_ST_W-1:0] : `PGIA_ST_RST;

    // sticky flags
    always @* begin
        fault_stat_next = (fault_stat_reg & ~w1c_mask) | stat_set; // RULE_17
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // gain, with automatic restore taking priority
    always @* begin
        gain_select_next = gain_select_reg;
        if (restore_fire) begin
            gain_select_next = `PGIA_GAIN_RST; // RULE_13
        end else if (wr_fire && PADDR_IN == `PGIA_OFF_GAIN) begin
            gain_select_next = PWDATA_IN[`PGIA_GAIN_W-1:0];
        end
    end

    // switch control, masks and interrupt enables
    always @* begin
        switch_ctrl_next = switch_ctrl_reg;
        fault_mask_next = fault_mask_reg;
        irq_en_next = irq_en_reg;
        if (wr_fire && PADDR_IN == `PGIA_OFF_SW) begin
            switch_ctrl_next = PWDATA_IN[`PGIA_SW_W-1:0];
        end
        if (wr_fire && PADDR_IN == `PGIA_OFF_DIS) begin
            fault_mask_next = PWDATA_IN[`PGIA_DIS_W-1:0];
        end
        if (wr_fire && PADDR_IN == `PGIA_OFF_IRQEN) begin
            irq_en_next = PWDATA_IN[`PGIA_ST_W-1:0];
        end
    end

    // register update
    always @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            gain_select_reg <= `PGIA_GAIN_RST;
            switch_ctrl_reg <= `PGIA_SW_RST;
            fault_stat_reg <= `PGIA_ST_RST;
            fault_mask_reg <= `PGIA_DIS_RST;
            irq_en_reg <= `PGIA_IRQEN_RST;
            clip_cnt_reg <= {`PGIA_CNT_W{1'b0}};
        end else begin
            gain_select_reg <= gain_select_next;
            switch_ctrl_reg <= switch_ctrl_next;
            fault_stat_reg <= fault_stat_next;
            fault_mask_reg <= fault_mask_next;
            irq_en_reg <= irq_en_next;
            clip_cnt_reg <= clip_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // switch protection
    // ------------------------------------------------------------
    // flag held means channel switches open
    assign ov_open = fault_stat_reg[`PGIA_ST_OV]; // RULE_08
    assign guard_on = ~fault_mask_reg[`PGIA_DIS_GUARD]; // RULE_10 RULE_11
    assign ch1_req = switch_ctrl_reg[`PGIA_SW_C1P] |
        switch_ctrl_reg[`PGIA_SW_C1N];
    // with the guard on, channel one wins a double selection
    assign ch2_block = guard_on & ch1_req; // RULE_10

    // registered switch drives
    always @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            sw_c1p_reg <= 1'b0;
            sw_c1n_reg <= 1'b0;
            sw_c2p_reg <= 1'b0;
            sw_c2n_reg <= 1'b0;
            sw_tp_reg <= 1'b0;
            sw_tn_reg <= 1'b0;
            sw_sh_reg <= 1'b0;
        end else begin
            sw_c1p_reg <= switch_ctrl_reg[`PGIA_SW_C1P] & ~ov_open; // RULE_04
            sw_c1n_reg <= switch_ctrl_reg[`PGIA_SW_C1N] & ~ov_open; // RULE_04
            sw_c2p_reg <= switch_ctrl_reg[`PGIA_SW_C2P] &
                ~ov_open & ~ch2_block; // RULE_08
            sw_c2n_reg <= switch_ctrl_reg[`PGIA_SW_C2N] &
                ~ov_open & ~ch2_block; // RULE_08
            sw_tp_reg <= switch_ctrl_reg[`PGIA_SW_TP]; // RULE_05
            sw_tn_reg <= switch_ctrl_reg[`PGIA_SW_TN]; // RULE_05
            sw_sh_reg <= switch_ctrl_reg[`PGIA_SW_SH]; // RULE_06
        end
    end

    // ------------------------------------------------------------
    // gain decode
    // ------------------------------------------------------------
    pgia_gain_dec u_dec (
        .clk(CLK_IN),
        .resetn(RESETN_IN),
        .in_gain(gain_select_reg[`PGIA_IG_MSB:`PGIA_IG_LSB]),
        .out_scale(gain_select_reg[`PGIA_OS_MSB:`PGIA_OS_LSB]),
        .in_res_sel(IN_RES_SEL_OUT),
        .out_res_sel(OUT_RES_SEL_OUT),
        .total_gain(GAIN_OUT)
    );

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // level while any enabled flag is set
    always @(posedge CLK_IN) begin
        if (!RESETN_IN) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(fault_stat_reg & irq_en_reg);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PRDATA_OUT = prdata_reg;
    assign PREADY_OUT = pready_reg;
    assign PSLVERR_OUT = pslverr_reg;
    assign CH1_POS_SWITCH_OUT = sw_c1p_reg;
    assign CH1_NEG_SWITCH_OUT = sw_c1n_reg;
    assign CH2_POS_SWITCH_OUT = sw_c2p_reg;
    assign CH2_NEG_SWITCH_OUT = sw_c2n_reg;
    assign TEST_ROUTE_SWITCH_POS_OUT = sw_tp_reg;
    assign TEST_ROUTE_SWITCH_NEG_OUT = sw_tn_reg;
    assign INPUT_SHORT_SWITCH_OUT = sw_sh_reg;
    assign IRQ_OUT = irq_reg;

endmodule

//--- rtl/pgia_defs.vh
// Overview of operation
// RULE_01: gain nibble selects twelve input resistors
// RULE_02: scale field selects three output resistors
// RULE_03: total gain is input times scale
// RULE_04: switch bits drive four channel switches
// RULE_05: two switches route to test multiplexer
// RULE_06: short switch ties multiplexer inputs together
// RULE_07: over-voltage sets the over-voltage flag
// RULE_08: over-voltage flag forces channel switches open
// RULE_09: disable bit blocks the over-voltage flag
// RULE_10: both channels never closed by default
// RULE_11: guard-off bit allows both channels together
// RULE_12: any clipping stage sets amplifier error
// RULE_13: clipping over 200 us restores gain
// RULE_14: restore may raise checksum fault, tolerated
// RULE_15: restore-off bit suppresses the gain restore
// RULE_16: persistence timer restarts when clipping stops
// RULE_17: error flags sticky until software clears
`ifndef PGIA_DEFS_VH
`define PGIA_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define PGIA_OFF_GAIN 8'h00
`define PGIA_OFF_SW 8'h04
`define PGIA_OFF_STAT 8'h08
`define PGIA_OFF_DIS 8'h0c
`define PGIA_OFF_IRQEN 8'h10
`define PGIA_OFF_LIVE 8'h14

// ------------------------------------------------------------
// field layout
// ------------------------------------------------------------
`define PGIA_IG_MSB 3
`define PGIA_IG_LSB 0
`define PGIA_OS_MSB 5
`define PGIA_OS_LSB 4
`define PGIA_GAIN_W 6
`define PGIA_SW_C1P 0
`define PGIA_SW_C1N 1
`define PGIA_SW_C2P 2
`define PGIA_SW_C2N 3
`define PGIA_SW_TP 4
`define PGIA_SW_TN 5
`define PGIA_SW_SH 6
`define PGIA_SW_W 7
`define PGIA_ST_OV 0
`define PGIA_ST_CLIP 1
`define PGIA_ST_GRST 2
`define PGIA_ST_CRC 3
`define PGIA_ST_W 4
`define PGIA_DIS_OV 0
`define PGIA_DIS_GUARD 1
`define PGIA_DIS_GRST 2
`define PGIA_DIS_W 3
`define PGIA_CLIP_W 8
`define PGIA_LIVE_W 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PGIA_GAIN_RST 6'h04
`define PGIA_SW_RST 7'h00
`define PGIA_ST_RST 4'h0
`define PGIA_DIS_RST 3'h0
`define PGIA_IRQEN_RST 4'h0

// ------------------------------------------------------------
// gain decode
// ------------------------------------------------------------
`define PGIA_IG_MAX 4'hb
`define PGIA_OS_X1 2'h0
`define PGIA_OS_X125 2'h1
`define PGIA_K_X1 15'h0008
`define PGIA_K_X125 15'h000a
`define PGIA_K_X1375 15'h000b
`define PGIA_IRES_W 12
`define PGIA_ORES_W 3
`define PGIA_TOT_W 15

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PGIA_CLK_MHZ 100
`define PGIA_CLIP_HOLD_US 200
`define PGIA_CNT_W 16

`endif

//--- rtl/pgia_sync.v
`timescale 1ns/1ps
`include "pgia_defs.vh"

module pgia_sync #(
    parameter W = 1
) (
    // clock and reset
    input wire clk,
    input wire resetn,
    // asynchronous levels in, synchronised levels out
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);

    // ------------------------------------------------------------
    // two flip-flop chain per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_reg;
            reg sync_reg;
            // first stage feeds only the second
            always @(posedge clk) begin
                if (!resetn) begin
                    meta_reg <= 1'b0;
                    sync_reg <= 1'b0;
                end else begin
                    meta_reg <= d_in[i];
                    sync_reg <= meta_reg;
                end
            end
            assign q_out[i] = sync_reg;
        end
    endgenerate

endmodule

//--- rtl/pgia_gain_dec.v
`timescale 1ns/1ps
`include "pgia_defs.vh"

module pgia_gain_dec (
    // clock and reset
    input wire clk,
    input wire resetn,
    // gain fields
    input wire [3:0] in_gain,
    input wire [1:0] out_scale,
    // resistor selects and total gain
    output reg [`PGIA_IRES_W-1:0] in_res_sel,
    output reg [`PGIA_ORES_W-1:0] out_res_sel,
    output reg [`PGIA_TOT_W-1:0] total_gain
);

    reg [3:0] code_eff;
    reg [`PGIA_TOT_W-1:0] scale_k;
    reg [`PGIA_ORES_W-1:0] out_sel;

    // ------------------------------------------------------------
    // combinational decode
    // ------------------------------------------------------------
    // codes above eleven clamp to the top gain
    always @* begin
        code_eff = in_gain; // RULE_01
        if (in_gain > `PGIA_IG_MAX) begin
            code_eff = `PGIA_IG_MAX;
        end
        case (out_scale) // RULE_02
            `PGIA_OS_X1: begin
                scale_k = `PGIA_K_X1;
                out_sel = 3'h1;
            end
            `PGIA_OS_X125: begin
                scale_k = `PGIA_K_X125;
                out_sel = 3'h2;
            end
            default: begin
                scale_k = `PGIA_K_X1375;
                out_sel = 3'h4;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registered selects; gain in units of 1/8 V/V
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            in_res_sel <= {`PGIA_IRES_W{1'b0}};
            out_res_sel <= {`PGIA_ORES_W{1'b0}};
            total_gain <= {`PGIA_TOT_W{1'b0}};
        end else begin
            in_res_sel <= 12'h001 << code_eff; // RULE_01
            out_res_sel <= out_sel; // RULE_02
            total_gain <= scale_k << code_eff; // RULE_03
        end
    end

endmodule

//--- testbench/pgia_checker.sv
`timescale 1ns/1ps
`include "pgia_defs.vh"

module pgia_checker #(
    parameter [`PGIA_CNT_W-1:0] CLIP_HOLD_CYC = 16'd20000
) (
    // clock and reset
    input wire CLK_IN,
    input wire RESETN_IN,
    // apb side
    input wire PSEL_IN,
    input wire PENABLE_IN,
    input wire PWRITE_IN,
    input wire [7:0] PADDR_IN,
    input wire [31:0] PWDATA_IN,
    input wire [31:0] PRDATA_OUT,
    input wire PREADY_OUT,
    input wire PSLVERR_OUT,
    // monitors
    input wire OVERVOLT_IN,
    input wire [`PGIA_CLIP_W-1:0] CLIP_IN,
    // switches and gain
    input wire CH1_POS_SWITCH_OUT,
    input wire CH1_NEG_SWITCH_OUT,
    input wire CH2_POS_SWITCH_OUT,
    input wire CH2_NEG_SWITCH_OUT,
    input wire TEST_ROUTE_SWITCH_POS_OUT,
    input wire TEST_ROUTE_SWITCH_NEG_OUT,
    input wire INPUT_SHORT_SWITCH_OUT,
    input wire [`PGIA_IRES_W-1:0] IN_RES_SEL_OUT,
    input wire [`PGIA_ORES_W-1:0] OUT_RES_SEL_OUT,
    input wire [`PGIA_TOT_W-1:0] GAIN_OUT
);
    logic rst_seen;
    logic [6:0] sw_q;
    logic [2:0] dis_q;
    logic [15:0] clip_cnt;
    logic [14:0] gain_exp;
    wire commit = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
    wire guard_off = dis_q[1];
    wire [2:0] aux_q = sw_q[6:4];
    wire ch1_any = CH1_POS_SWITCH_OUT || CH1_NEG_SWITCH_OUT;
    wire ch2_any = CH2_POS_SWITCH_OUT || CH2_NEG_SWITCH_OUT;

    // mirror of control writes and of the clipping duration
    always @(posedge CLK_IN) begin
        rst_seen <= RESETN_IN;
        if (!RESETN_IN) begin
            sw_q <= 7'h00;
            dis_q <= 3'h0;
        end else if (commit && PADDR_IN == `PGIA_OFF_SW) begin
            sw_q <= PWDATA_IN[6:0];
        end else if (commit && PADDR_IN == `PGIA_OFF_DIS) begin
            dis_q <= PWDATA_IN[2:0];
        end
        if (!RESETN_IN || CLIP_IN == 8'h00) begin
            clip_cnt <= 16'h0000;
        end else if (clip_cnt != 16'hffff) begin
            clip_cnt <= clip_cnt + 16'h0001;
        end
    end

    // expected total gain from the two resistor selects
    always @* begin
        gain_exp = 15'h0000;
        for (int i = 0; i < 12; i++) begin
            if (IN_RES_SEL_OUT[i]) begin
                gain_exp = (OUT_RES_SEL_OUT[2] ? 15'h000b :
                    OUT_RES_SEL_OUT[1] ? 15'h000a : 15'h0008) << i;
            end
        end
    end

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    sequence s_setup;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence s_access;
        PSEL_IN && PENABLE_IN;
    endsequence

    a_ready_wait: assert property (s_setup ##1 s_access |->
        !PREADY_OUT ##1 PREADY_OUT) else $error("ready wait wrong");
    a_ready_pulse: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready held too long");
    a_rdata_idle: assert property (!PREADY_OUT |-> PRDATA_OUT == 32'h0)
        else $error("read data outside answer");
    a_slverr_map: assert property (PREADY_OUT && PADDR_IN[1:0] == 2'h0 |->
        PSLVERR_OUT == (PADDR_IN > `PGIA_OFF_LIVE)) else $error("bad slverr");
    a_dual_guard: assert property (
        !guard_off && !$past(guard_off) |-> !(ch1_any && ch2_any))
        else $error("both channels closed");
    a_ov_open: assert property (
        (OVERVOLT_IN && !dis_q[0])[*6] |-> !(ch1_any || ch2_any))
        else $error("channel closed in over-voltage");
    a_aux_switches: assert property (
        rst_seen |-> {INPUT_SHORT_SWITCH_OUT, TEST_ROUTE_SWITCH_NEG_OUT,
        TEST_ROUTE_SWITCH_POS_OUT} == $past(aux_q))
        else $error("test or short switch wrong");
    a_gain_onehot: assert property (
        rst_seen |-> $onehot(IN_RES_SEL_OUT) && $onehot(OUT_RES_SEL_OUT))
        else $error("resistor select not one-hot");
    a_gain_product: assert property (
        rst_seen |-> GAIN_OUT == gain_exp) else $error("total gain wrong");
    a_clip_restore: assert property (
        clip_cnt == CLIP_HOLD_CYC + 16'd6 && !dis_q[2] |->
        GAIN_OUT == 15'h0080) else $error("gain not restored");
endmodule

bind pgia_top pgia_checker #(.CLIP_HOLD_CYC(CLIP_HOLD_CYC)) u_chk (.*);

//--- testbench/pgia_sensor_model.sv
`timescale 1ns/1ps

module pgia_sensor_model (
    // clock
    input wire clk_in,
    // scenario commands
    input wire ov_cmd_in,
    input wire clip_cmd_in,
    // monitor levels toward the device
    output logic ov_out,
    output logic [7:0] clip_out
);
    logic [7:0] stage_reg;

    // quiet sensors at time zero
    initial begin
        ov_out = 1'b0;
        clip_out = 8'h00;
        stage_reg = 8'h01;
    end

    // clipping wanders across stages, so no single stage stays high
    always @(posedge clk_in) begin
        ov_out <= ov_cmd_in;
        stage_reg <= {stage_reg[6:0], stage_reg[7]};
        clip_out <= clip_cmd_in ? stage_reg : 8'h00;
    end
endmodule

//--- testbench/tb_pgia_gain_select_register_protection.sv
`timescale 1ns/1ps
`include "pgia_defs.vh"
`define CHK(g, e) \
    begin \
        n_compared++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("BAD %0t got %h exp %h", $time, g, e); \
        end \
    end

module tb_pgia_gain_select_register_protection;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic ov_cmd = 1'b0;
    logic clip_cmd = 1'b0;
    logic crc = 1'b0;
    wire ov;
    wire [7:0] clip;
    wire [31:0] prdata;
    wire pready;
    wire pslverr;
    wire [6:0] sw;
    wire [11:0] in_sel;
    wire [2:0] out_sel;
    wire [14:0] gain;
    wire irq;
    logic [31:0] rd_data;
    logic rd_err;
    logic [14:0] k;
    int n;
    int n_errors = 0;
    int n_compared = 0;

    always #5 clk = ~clk;

    pgia_sensor_model sensors (.clk_in(clk), .ov_cmd_in(ov_cmd),
        .clip_cmd_in(clip_cmd), .ov_out(ov), .clip_out(clip));

    pgia_top #(.CLIP_HOLD_CYC(16'd20)) dut (
        .CLK_IN(clk), .RESETN_IN(rstn), .PSEL_IN(psel),
        .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
        .PSLVERR_OUT(pslverr), .OVERVOLT_IN(ov), .CLIP_IN(clip),
        .REGMAP_CRC_FAULT_IN(crc), .CH1_POS_SWITCH_OUT(sw[0]),
        .CH1_NEG_SWITCH_OUT(sw[1]), .CH2_POS_SWITCH_OUT(sw[2]),
        .CH2_NEG_SWITCH_OUT(sw[3]), .TEST_ROUTE_SWITCH_POS_OUT(sw[4]),
        .TEST_ROUTE_SWITCH_NEG_OUT(sw[5]), .INPUT_SHORT_SWITCH_OUT(sw[6]),
        .IN_RES_SEL_OUT(in_sel), .OUT_RES_SEL_OUT(out_sel),
        .GAIN_OUT(gain), .IRQ_OUT(irq));

    // ------------------------------------------------------------
    // bus and scenario tasks
    // ------------------------------------------------------------
    // one apb transfer, held until ready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && t < 20) begin
            @(posedge clk);
            t++;
        end
        if (t == 20) n_errors++;
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd_data, e)
    endtask

    // wait whole cycles, then look where outputs are settled
    task automatic hold(input int c);
        repeat (c) @(negedge clk);
    endtask

    task automatic clip_for(input int c);
        @(posedge clk);
        clip_cmd <= 1'b1;
        repeat (c) @(posedge clk);
        clip_cmd <= 1'b0;
    endtask

    task automatic complete_run;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        hold(2);
        `CHK(gain, 15'h0080)
        for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), i == 0 ? 32'h4 : 32'h0);
        apb(1'b1, 8'h20, 32'hffff_ffff);
        `CHK(rd_err, 1'b1)
        rd_chk(8'h18, 32'h0);
        `CHK(rd_err, 1'b1)
        // every input gain code against every scale code
        for (int s = 0; s < 4; s++) begin
            for (int g = 0; g < 16; g++) begin
                n = g > 11 ? 11 : g;
                k = s == 0 ? 15'h0008 : s == 1 ? 15'h000a : 15'h000b;
                apb(1'b1, `PGIA_OFF_GAIN, 32'(s * 16 + g));
                hold(2);
                `CHK(in_sel, 12'h001 << n)
                `CHK(out_sel, 3'h1 << (s > 2 ? 2 : s))
                `CHK(gain, k << n)
            end
        end
        // each switch alone, then all with the guard on and off
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `PGIA_OFF_SW, 32'h1 << i);
            hold(2);
            `CHK(sw, 7'h01 << i)
        end
        apb(1'b1, `PGIA_OFF_SW, 32'h7f);
        hold(2);
        `CHK(sw, 7'h73)
        apb(1'b1, `PGIA_OFF_DIS, 32'h2);
        hold(2);
        `CHK(sw, 7'h7f)
        // over-voltage, interrupt masked then enabled, sticky flag
        @(posedge clk);
        ov_cmd <= 1'b1;
        hold(8);
        `CHK(sw, 7'h70)
        `CHK(irq, 1'b0)
        rd_chk(`PGIA_OFF_STAT, 32'h1);
        rd_chk(`PGIA_OFF_LIVE, 32'h1);
        apb(1'b1, `PGIA_OFF_IRQEN, 32'h1);
        hold(3);
        `CHK(irq, 1'b1)
        @(posedge clk);
        ov_cmd <= 1'b0;
        hold(8);
        `CHK(sw, 7'h70)
        apb(1'b1, `PGIA_OFF_STAT, 32'hf);
        hold(3);
        `CHK(irq, 1'b0)
        `CHK(sw, 7'h7f)
        // over-voltage flag turned off
        apb(1'b1, `PGIA_OFF_DIS, 32'h3);
        @(posedge clk);
        ov_cmd <= 1'b1;
        hold(8);
        `CHK(sw, 7'h7f)
        rd_chk(`PGIA_OFF_STAT, 32'h0);
        ov_cmd <= 1'b0;
        crc <= 1'b1;
        @(posedge clk);
        crc <= 1'b0;
        rd_chk(`PGIA_OFF_STAT, 32'h8);
        `CHK(irq, 1'b0)
        apb(1'b1, `PGIA_OFF_STAT, 32'hf);
        // short clipping bursts restart the timer
        apb(1'b1, `PGIA_OFF_GAIN, 32'h2b);
        clip_for(10);
        hold(4);
        clip_for(15);
        hold(6);
        rd_chk(`PGIA_OFF_GAIN, 32'h2b);
        rd_chk(`PGIA_OFF_STAT, 32'h2);
        clip_for(40);
        hold(6);
        `CHK(gain, 15'h0080)
        rd_chk(`PGIA_OFF_GAIN, 32'h4);
        rd_chk(`PGIA_OFF_STAT, 32'he);
        // restore turned off
        apb(1'b1, `PGIA_OFF_STAT, 32'hf);
        apb(1'b1, `PGIA_OFF_DIS, 32'h6);
        apb(1'b1, `PGIA_OFF_GAIN, 32'h2b);
        clip_for(40);
        hold(6);
        rd_chk(`PGIA_OFF_GAIN, 32'h2b);
        rd_chk(`PGIA_OFF_STAT, 32'h2);
        complete_run;
    end

    // cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run;
    end
endmodule
